/* inc/lvd_pkg.sv */
// Purpose: Shared constants and types of the low-voltage detector control block
// Assumes: 32-bit AHB-Lite register bus, byte addresses as printed
// Notes:   Register widths are 8 bits, placed in the low byte of each word
package lvd_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [31:0] ADDR_CONTROL      = 32'h0fff_f890;
   localparam logic [31:0] ADDR_LEVEL_SELECT = 32'h0fff_f894;
   localparam logic [31:0] ADDR_PROTECT_CMD  = 32'h0fff_f898;
   localparam logic [31:0] ADDR_RESET_SOURCE = 32'h0fff_f89c;

   // ----------------------------------------------------------------
   // Field positions and values
   // ----------------------------------------------------------------
   localparam int          BIT_ENABLE        = 7;
   localparam int          BIT_ACTION        = 1;
   localparam int          BIT_FLAG          = 0;
   localparam int          BIT_DET_RESET_SRC = 0;
   localparam int          LEVEL_WIDTH       = 3;
   localparam logic [2:0]  LEVEL_PROHIBITED  = 3'h7;
   localparam logic [7:0]  PROTECT_KEY       = 8'ha5;
   localparam logic [7:0]  RESET_CONTROL     = 8'h00;
   localparam logic [7:0]  RESET_LEVEL       = 8'h00;
   localparam int          SYNC_STAGES       = 2;

   // ----------------------------------------------------------------
   // AHB-Lite encodings
   // ----------------------------------------------------------------
   localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;
   localparam logic        HRESP_OKAY        = 1'b0;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [2:0]  size;
   } lvd_addr_phase_t;

   typedef struct packed {
      logic        enable;
      logic        action;
   } lvd_control_t;

   typedef enum logic [1:0] {
      LVD_PROT_CLOSED = 2'b01,
      LVD_PROT_OPEN   = 2'b10
   } lvd_prot_state_t;

endpackage : lvd_pkg

/* hdl/lvd_sync.sv */
// Purpose: Multi-stage synchroniser for an asynchronous level
// Assumes: Input changes slowly relative to hclk
// Notes:   Only the last stage is visible outside
`timescale 1ns/10ps
`default_nettype none
module lvd_sync #(
   parameter int STAGES = 2
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic async_in,
   output var  logic sync_out
);

   logic [STAGES-1:0] chain;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chain <= '0;
      end else begin
         chain <= {chain[STAGES-2:0], async_in};
      end
   end

   assign sync_out = chain[STAGES-1];

endmodule : lvd_sync
`default_nettype wire

/* hdl/lvd_protect.sv */
// Purpose: Special-write sequencer guarding the control register
// Assumes: One bus write completes per data phase
// Notes:   Key write opens exactly one following write
`timescale 1ns/10ps
`default_nettype none
module lvd_protect (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic key_write,
   input  wire logic any_write,
   output var  logic open_now
);

   lvd_pkg::lvd_prot_state_t state;

   // Any other write after the key closes the window again
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= lvd_pkg::LVD_PROT_CLOSED;
      end else begin
         case (state)
            lvd_pkg::LVD_PROT_CLOSED: begin
               if (key_write) begin
                  state <= lvd_pkg::LVD_PROT_OPEN;
               end
            end
            lvd_pkg::LVD_PROT_OPEN: begin
               if (any_write && !key_write) begin
                  state <= lvd_pkg::LVD_PROT_CLOSED;
               end
            end
            default: begin
               state <= lvd_pkg::LVD_PROT_CLOSED;
            end
         endcase
      end
   end

   assign open_now = (state == lvd_pkg::LVD_PROT_OPEN);

endmodule : lvd_protect
`default_nettype wire

/* hdl/lvd_ctrl.sv */
// Purpose: Control logic of a low-voltage detector behind an AHB-Lite slave
// Assumes: hresetn is every reset except the detector's own
// Notes:   Summary of operation follows
`timescale 1ns/10ps
`default_nettype none
module lvd_ctrl #(
   parameter int SYNC_STAGES = lvd_pkg::SYNC_STAGES
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic        hreadyout,
   output var  logic        hresp,
   output var  logic [31:0] hrdata,
   input  wire logic        supply_below,
   output var  logic [2:0]  detect_level_select,
   output var  logic        low_supply_irq,
   output var  logic        low_supply_reset
);

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   // Low byte lane is touched only when the access starts at offset 0
   function automatic logic lane0_hit(input logic [31:0] addr);
      lane0_hit = (addr[1:0] == 2'b00);
   endfunction : lane0_hit

   function automatic logic is_reg(input logic [31:0] addr, input logic [31:0] base);
      is_reg = ({addr[31:2], 2'b00} == base);
   endfunction : is_reg

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   lvd_pkg::lvd_addr_phase_t ap;
   lvd_pkg::lvd_control_t    control;
   logic [2:0]               level_code;
   logic                     below_sync;
   logic                     below_level_flag;
   logic                     detector_reset_source_flag;
   logic                     prot_open;
   logic                     data_write;
   logic                     lane0_write;
   logic                     key_write;
   logic                     locked;
   logic                     ctrl_write_ok;
   logic                     level_write_ok;
   logic [7:0]               wbyte;
   logic [31:0]              next_rdata;

   // ----------------------------------------------------------------
   // Comparator synchroniser
   // ----------------------------------------------------------------
   lvd_sync #(
      .STAGES   (SYNC_STAGES)
   ) u_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in (supply_below),
      .sync_out (below_sync)
   );

   // ----------------------------------------------------------------
   // AHB-Lite address phase capture
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap <= '0;
      end else if (hready) begin
         ap.valid <= hsel && (htrans == lvd_pkg::HTRANS_NONSEQ || htrans == 2'h3);
         ap.write <= hwrite;
         ap.addr  <= haddr;
         ap.size  <= hsize;
      end
   end

   // Zero-wait slave; always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b0;
         hresp     <= lvd_pkg::HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= lvd_pkg::HRESP_OKAY;
      end
   end

   assign data_write  = ap.valid && ap.write;
   assign lane0_write = data_write && lane0_hit(ap.addr);
   assign wbyte       = hwdata[7:0];
   assign key_write   = lane0_write && is_reg(ap.addr, lvd_pkg::ADDR_PROTECT_CMD)
                        && (wbyte == lvd_pkg::PROTECT_KEY);

   // ----------------------------------------------------------------
   // Protected write sequence
   // ----------------------------------------------------------------
   lvd_protect u_protect (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .key_write (key_write),
      .any_write (data_write),
      .open_now  (prot_open)
   );

   assign locked = control.enable && control.action;

   // Ordinary writes fall through silently
   assign ctrl_write_ok  = lane0_write && is_reg(ap.addr, lvd_pkg::ADDR_CONTROL)
                           && prot_open && !locked;
   assign level_write_ok = lane0_write && is_reg(ap.addr, lvd_pkg::ADDR_LEVEL_SELECT)
                           && !locked
                           && (wbyte[2:0] != lvd_pkg::LEVEL_PROHIBITED);

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   // Only hresetn clears it, so the detector's own reset leaves it intact
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         control <= '0;
      end else if (ctrl_write_ok) begin
         control.enable <= wbyte[lvd_pkg::BIT_ENABLE];
         control.action <= wbyte[lvd_pkg::BIT_ACTION];
      end
   end

   // ----------------------------------------------------------------
   // Level select register
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         level_code <= lvd_pkg::RESET_LEVEL[2:0];
      end else if (level_write_ok) begin
         level_code <= wbyte[2:0];
      end
   end

   // ----------------------------------------------------------------
   // Flag and actions
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         below_level_flag <= 1'b0;
      end else begin
         below_level_flag <= below_sync && control.enable;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_supply_irq   <= 1'b0;
         low_supply_reset <= 1'b0;
      end else begin
         // Clearing enable stops interrupts; reset mode cannot be cleared
         low_supply_irq   <= below_sync && control.enable && !control.action;
         low_supply_reset <= below_sync && control.enable && control.action;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         detect_level_select <= lvd_pkg::RESET_LEVEL[2:0];
      end else begin
         detect_level_select <= level_code;
      end
   end

   // ----------------------------------------------------------------
   // Reset source flag
   // ----------------------------------------------------------------
   // Set beats a simultaneous software clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         detector_reset_source_flag <= 1'b0;
      end else if (low_supply_reset) begin
         detector_reset_source_flag <= 1'b1;
      end else if (lane0_write && is_reg(ap.addr, lvd_pkg::ADDR_RESET_SOURCE)
                   && wbyte[lvd_pkg::BIT_DET_RESET_SRC]) begin
         detector_reset_source_flag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_comb begin
      next_rdata = '0;
      if (is_reg(haddr, lvd_pkg::ADDR_CONTROL)) begin
         // Bits 6..2 always read zero; flag bit has no write path
         next_rdata[lvd_pkg::BIT_ENABLE] = control.enable;
         next_rdata[lvd_pkg::BIT_ACTION] = control.action;
         next_rdata[lvd_pkg::BIT_FLAG]   = below_level_flag;
      end else if (is_reg(haddr, lvd_pkg::ADDR_LEVEL_SELECT)) begin
         next_rdata[2:0] = level_code;
      end else if (is_reg(haddr, lvd_pkg::ADDR_PROTECT_CMD)) begin
         next_rdata[0] = prot_open;
      end else if (is_reg(haddr, lvd_pkg::ADDR_RESET_SOURCE)) begin
         next_rdata[lvd_pkg::BIT_DET_RESET_SRC] = detector_reset_source_flag;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         hrdata <= next_rdata;
      end
   end

endmodule : lvd_ctrl
`default_nettype wire

/* sim/lvd_supply_model.sv */
// Purpose: Supply comparator standing at the far side of the detector
// Assumes: Supply given as a step code, higher code is lower voltage
// Notes:   Step 7 sits below every legal detection level
`timescale 1ns/10ps
`default_nettype none
module lvd_supply_model (
   input  wire logic [2:0] supply_code,
   input  wire logic [2:0] detect_level_select,
   output var  logic       supply_below
);
   // Unclocked on purpose: the real comparator has no clock
   always_comb supply_below = supply_code > detect_level_select;
endmodule : lvd_supply_model
`default_nettype wire

/* sim/lvd_ctrl_chk.sv */
// Purpose: Port-level assertions for the detector control block
// Assumes: One hclk domain, hresetn asynchronous active low
// Notes:   Bound to lvd_ctrl from the testbench top
`timescale 1ns/10ps
`default_nettype none
module lvd_ctrl_chk (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        supply_below,
   input wire logic [2:0]  detect_level_select,
   input wire logic        low_supply_irq,
   input wire logic        low_supply_reset
);
   logic lvl_wr;
   assign lvl_wr = hsel && hready && htrans == lvd_pkg::HTRANS_NONSEQ && hwrite
                   && haddr == lvd_pkg::ADDR_LEVEL_SELECT;
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   chk_path_exclusive: assert property (!(low_supply_irq && low_supply_reset))
      else $error("interrupt and reset raised together");
   chk_irq_cause: assert property (low_supply_irq |-> $past(supply_below, 3))
      else $error("interrupt without low supply three edges before");
   chk_reset_cause: assert property (low_supply_reset |-> $past(supply_below, 3))
      else $error("reset without low supply three edges before");
   chk_reset_no_irq: assert property (low_supply_reset |=> !low_supply_irq [*8])
      else $error("interrupt after reset mode was locked");
   // Ready rises one edge after reset release, so the first edge is exempt
   chk_resp_okay: assert property (hresp == lvd_pkg::HRESP_OKAY && (hreadyout || !$past(hresetn)))
      else $error("slave not ready or not okay");
   chk_level_legal: assert property (detect_level_select != lvd_pkg::LEVEL_PROHIBITED)
      else $error("prohibited level code driven");
   chk_level_locked: assert property (low_supply_reset |=> $stable(detect_level_select))
      else $error("level changed while locked");
   chk_level_cause: assert property (!$stable(detect_level_select) |-> $past(lvl_wr, 2) || $past(lvl_wr, 3))
      else $error("level changed without a level write");
endmodule : lvd_ctrl_chk
`default_nettype wire

/* sim/lvd_ctrl_test.sv */
// Purpose: Self-checking testbench of the detector control block
// Assumes: Zero-wait AHB-Lite slave, word transfers only
// Notes:   Supply is stepped through the comparator model
`timescale 1ns/10ps
`default_nettype none
module lvd_ctrl_test;
   localparam logic [31:0] A_CTL = lvd_pkg::ADDR_CONTROL;
   localparam logic [31:0] A_LVL = lvd_pkg::ADDR_LEVEL_SELECT;
   localparam logic [31:0] A_KEY = lvd_pkg::ADDR_PROTECT_CMD;
   localparam logic [31:0] A_SRC = lvd_pkg::ADDR_RESET_SOURCE;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic        supply_below, low_supply_irq, low_supply_reset;
   logic [1:0]  htrans;
   logic [2:0]  hsize, detect_level_select, supply_code;
   logic [31:0] haddr, hwdata, hrdata, rd;
   int          fails = 0;
   int          n_tests = 0;
   int          cycles = 0;
   assign hready = hreadyout;
   lvd_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .supply_below(supply_below),
      .detect_level_select(detect_level_select), .low_supply_irq(low_supply_irq),
      .low_supply_reset(low_supply_reset));
   lvd_supply_model u_supply (.supply_code(supply_code), .detect_level_select(detect_level_select),
      .supply_below(supply_below));
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   // Whole run needs well under a thousand cycles
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         finish_test();
      end
   end
   task finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   task check(input string name, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= lvd_pkg::HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'h2;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask : bus
   task rdchk(input string name, input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      check(name, rd, exp);
   endtask : rdchk
   task pwr(input logic [31:0] d);
      bus(1'b1, A_KEY, 32'h0000_00a5);
      bus(1'b1, A_CTL, d);
   endtask : pwr
   task supply(input logic [2:0] code);
      supply_code <= code;
      repeat (5) @(posedge hclk);
   endtask : supply
   // Level output lags the register by one edge; look after it has moved
   task settle();
      repeat (2) @(negedge hclk);
   endtask : settle
   task t_reset_values();
      rdchk("control", A_CTL, 32'h0000_0000);
      rdchk("level", A_LVL, 32'h0000_0000);
      rdchk("source", A_SRC, 32'h0000_0000);
      rdchk("unmapped", 32'h0fff_f8a0, 32'h0000_0000);
      $display("reset values done");
   endtask : t_reset_values
   task t_protect();
      bus(1'b1, A_CTL, 32'h0000_0080);
      rdchk("plain write", A_CTL, 32'h0000_0000);
      bus(1'b1, A_KEY, 32'h0000_00a5);
      bus(1'b1, A_LVL, 32'h0000_0003);
      bus(1'b1, A_CTL, 32'h0000_0080);
      rdchk("closed window", A_CTL, 32'h0000_0000);
      pwr(32'h0000_0081);
      rdchk("flag read only", A_CTL, 32'h0000_0080);
      $display("protection done");
   endtask : t_protect
   task t_irq();
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, A_LVL, 32'(i));
         settle();
         check("level out", 32'(detect_level_select), 32'(i));
      end
      bus(1'b1, A_LVL, 32'h0000_0007);
      rdchk("level 7 refused", A_LVL, 32'h0000_0006);
      supply(3'h7);
      check("irq", 32'(low_supply_irq), 32'h0000_0001);
      check("no reset", 32'(low_supply_reset), 32'h0000_0000);
      rdchk("flag low", A_CTL, 32'h0000_0081);
      supply(3'h0);
      check("irq off", 32'(low_supply_irq), 32'h0000_0000);
      supply(3'h7);
      pwr(32'h0000_0000);
      rdchk("disabled flag", A_CTL, 32'h0000_0000);
      check("irq stopped", 32'(low_supply_irq), 32'h0000_0000);
      $display("interrupt mode done");
   endtask : t_irq
   task t_reset_mode();
      supply(3'h0);
      pwr(32'h0000_0082);
      supply(3'h7);
      check("reset", 32'(low_supply_reset), 32'h0000_0001);
      check("irq quiet", 32'(low_supply_irq), 32'h0000_0000);
      rdchk("source set", A_SRC, 32'h0000_0001);
      pwr(32'h0000_0000);
      rdchk("locked", A_CTL, 32'h0000_0083);
      bus(1'b1, A_LVL, 32'h0000_0002);
      settle();
      check("level locked", 32'(detect_level_select), 32'h0000_0006);
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      rdchk("cleared", A_CTL, 32'h0000_0000);
      rdchk("level cleared", A_LVL, 32'h0000_0000);
      check("reset released", 32'(low_supply_reset), 32'h0000_0000);
      $display("reset mode done");
   endtask : t_reset_mode
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      supply_code = 3'h0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      t_reset_values();
      t_protect();
      t_irq();
      t_reset_mode();
      finish_test();
   end
endmodule : lvd_ctrl_test
bind lvd_ctrl lvd_ctrl_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .supply_below(supply_below),
   .detect_level_select(detect_level_select), .low_supply_irq(low_supply_irq),
   .low_supply_reset(low_supply_reset));
`default_nettype wire
